// *** core/uart_pkg.sv ***
// Overview of operation
// R1 - With divisor access set, offsets 0 and 1 reach the 16-bit divisor latch low and high bytes.
// R2 - With divisor access clear, offset 0 reads the receive buffer and writes the transmit buffer, offset 1 the interrupt enable.
// R3 - Force silence holds the infrared output low while the ordinary transmitter keeps running.
// R4 - Parity enable plus fixed parity sends and checks a constant parity bit, 0 when even select is 1, else 1.
// R5 - Parity enabled and not fixed gives even parity when even select is 1, odd parity when it is 0.
// R6 - With parity enabled a parity bit goes after the last data bit and before the stop bits, and is checked there.
// R7 - Stop bits are one, or one and a half for 5-bit characters, or two for longer ones when multi stop is set.
// R8 - The two-bit length field gives 5, 6, 7 or 8 data bits.
// R9 - The baud generator takes divisors 1 to 65535 and makes a tick at sixteen times the bit rate.
// R10 - A character is a start bit, data least significant first, optional parity, then stop bits.
// R11 - Eight consecutive offsets are decoded for the data, enable, status, control, scratch and divisor registers.
// R12 - The line format control register clears to zero on reset.
package uart_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_IEN = 3'h1;
    localparam logic [2:0] OFS_IID = 3'h2;
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_MSR = 3'h6;
    localparam logic [2:0] OFS_SCR = 3'h7;
    // Line format control fields
    localparam int LC_DLAB = 7;
    localparam int LC_SIL = 6;
    localparam int LC_FIX = 5;
    localparam int LC_EVEN = 4;
    localparam int LC_PEN = 3;
    localparam int LC_STB = 2;
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam logic [3:0] OVS = 4'hF;
    localparam logic [3:0] OVS_HALF = 4'h7;
    localparam logic [3:0] IEN_MASK = 4'hF;
    // Interrupt source bit positions
    localparam int EV_RX = 0;
    localparam int EV_TXE = 1;
    localparam int EV_ERR = 2;
    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} ser_t;
endpackage : uart_pkg

// *** core/uart_line_format_control.sv ***
module uart_line_format_control
    import uart_pkg::*;
(
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rstn_i,
    // Avalon-MM slave
    input wire logic [uart_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [uart_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [uart_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Serial line
    input wire logic serial_in_i,
    output logic serial_out_o,
    output logic infrared_tx_out_o,
    // Interrupt
    output logic irq_o
);
    import uart_pkg::*;

    // Registers
    logic [7:0] lcr_q, lcr_d;
    logic [15:0] div_q, div_d;
    logic [3:0] ien_q, ien_d;
    logic [7:0] scr_q, scr_d;
    logic [4:0] mcr_q, mcr_d;
    logic [7:0] thr_q, thr_d;
    logic thr_full_q, thr_full_d;
    logic [7:0] rxbuf_q, rxbuf_d;
    logic [2:0] sts_q, sts_d;
    logic [3:0] err_q, err_d;
    logic ack_q, ack_d;
    logic [7:0] rd_q, rd_d;
    // Baud generator
    logic [15:0] bcnt_q, bcnt_d;
    logic tick;
    // Transmitter
    ser_t ts_q, ts_d;
    logic [3:0] tov_q, tov_d;
    logic [2:0] tbit_q, tbit_d;
    logic [7:0] tsh_q, tsh_d;
    logic tpar_q, tpar_d;
    logic [1:0] tstop_q, tstop_d;
    logic tout_q, tout_d;
    logic tx_take;
    // Receiver
    ser_t rs_q, rs_d;
    logic [3:0] rov_q, rov_d;
    logic [2:0] rbit_q, rbit_d;
    logic [7:0] rsh_q, rsh_d;
    logic rpar_q, rpar_d;
    logic rx_done, rx_perr, rx_ferr;
    logic [2:0] nbits;
    logic acc;

    // Length field to highest data bit index
    function automatic logic [2:0] last_bit(input logic [1:0] len);
        last_bit = 3'h4 + {1'b0, len}; // R8
    endfunction : last_bit

    // Parity value for a running xor of data
    function automatic logic par_of(input logic [7:0] lc, input logic dxor);
        if (lc[LC_FIX]) begin
            par_of = ~lc[LC_EVEN]; // R4
        end else begin
            par_of = lc[LC_EVEN] ? dxor : ~dxor; // R5
        end
    endfunction : par_of

    assign nbits = last_bit(lcr_q[1:0]);
    assign acc = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
    assign avs_readdata_o = rd_q;
    assign irq_o = |(sts_q & ien_q[2:0]) & mcr_q[3];
    assign serial_out_o = tout_q;
    assign infrared_tx_out_o = lcr_q[LC_SIL] ? 1'b0 : tout_q; // R3

    // Register file and bus answer
    always_comb begin
        lcr_d = lcr_q;
        div_d = div_q;
        ien_d = ien_q;
        scr_d = scr_q;
        mcr_d = mcr_q;
        thr_d = thr_q;
        thr_full_d = thr_full_q & ~tx_take;
        rxbuf_d = rxbuf_q;
        sts_d = sts_q;
        err_d = err_q;
        rd_d = rd_q;
        ack_d = acc;
        if (tx_take) begin
            sts_d[EV_TXE] = 1'b1;
        end
        if (acc && avs_read_i) begin
            case (avs_address_i) // R11
                OFS_DATA: begin
                    if (lcr_q[LC_DLAB]) begin
                        rd_d = div_q[7:0]; // R1
                    end else begin
                        rd_d = rxbuf_q; // R2
                        sts_d[EV_RX] = 1'b0;
                    end
                end
                OFS_IEN: rd_d = lcr_q[LC_DLAB] ? div_q[15:8] : {4'h0, ien_q}; // R1 R2
                OFS_IID: rd_d = {5'h00, sts_q[EV_ERR] ? 2'h3 : sts_q[EV_RX] ? 2'h2 : 2'h1,
                    ~|(sts_q & ien_q[2:0])};
                OFS_LCR: rd_d = lcr_q;
                OFS_MCR: rd_d = {3'h0, mcr_q};
                OFS_LSR: begin
                    rd_d = {1'b0, ~thr_full_q & (ts_q == ST_IDLE), ~thr_full_q, 1'b0, err_q[2:0],
                        sts_q[EV_RX]};
                    err_d = 4'h0;
                    sts_d[EV_ERR] = 1'b0;
                end
                OFS_MSR: rd_d = 8'h00;
                OFS_SCR: rd_d = scr_q;
                default: rd_d = 8'h00;
            endcase
        end
        if (acc && avs_write_i) begin
            case (avs_address_i)
                OFS_DATA: begin
                    if (lcr_q[LC_DLAB]) begin
                        div_d[7:0] = avs_writedata_i; // R1
                    end else begin
                        thr_d = avs_writedata_i; // R2
                        thr_full_d = 1'b1;
                        sts_d[EV_TXE] = 1'b0;
                    end
                end
                OFS_IEN: begin
                    if (lcr_q[LC_DLAB]) begin
                        div_d[15:8] = avs_writedata_i; // R1
                    end else begin
                        ien_d = avs_writedata_i[3:0] & IEN_MASK; // R2
                    end
                end
                OFS_LCR: lcr_d = avs_writedata_i;
                OFS_MCR: mcr_d = avs_writedata_i[4:0];
                OFS_SCR: scr_d = avs_writedata_i;
                default: ;
            endcase
        end
        // Hardware events win over reads
        if (rx_done) begin
            rxbuf_d = rsh_q;
            if (sts_q[EV_RX]) begin
                err_d[0] = 1'b1;
            end
            sts_d[EV_RX] = 1'b1;
            err_d[1] = err_d[1] | rx_perr;
            err_d[2] = err_d[2] | rx_ferr;
            if (rx_perr || rx_ferr || sts_q[EV_RX]) begin
                sts_d[EV_ERR] = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lcr_q <= LCR_RST; // R12
            div_q <= DIV_RST;
            ien_q <= 4'h0;
            scr_q <= 8'h00;
            mcr_q <= 5'h00;
            thr_q <= 8'h00;
            thr_full_q <= 1'b0;
            rxbuf_q <= 8'h00;
            sts_q <= 3'h0;
            err_q <= 4'h0;
            rd_q <= 8'h00;
            ack_q <= 1'b0;
        end else begin
            lcr_q <= lcr_d;
            div_q <= div_d;
            ien_q <= ien_d;
            scr_q <= scr_d;
            mcr_q <= mcr_d;
            thr_q <= thr_d;
            thr_full_q <= thr_full_d;
            rxbuf_q <= rxbuf_d;
            sts_q <= sts_d;
            err_q <= err_d;
            rd_q <= rd_d;
            ack_q <= ack_d;
        end
    end

    // Sixteen-times baud tick, divisor zero treated as one
    always_comb begin
        tick = (bcnt_q <= 16'h0001);
        bcnt_d = tick ? div_q : bcnt_q - 16'h0001; // R9
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bcnt_q <= DIV_RST;
        end else begin
            bcnt_q <= bcnt_d;
        end
    end

    // Transmit framing
    assign tx_take = (ts_q == ST_IDLE) && thr_full_q && tick;
    always_comb begin
        ts_d = ts_q;
        tov_d = tov_q;
        tbit_d = tbit_q;
        tsh_d = tsh_q;
        tpar_d = tpar_q;
        tstop_d = tstop_q;
        tout_d = tout_q;
        if (tick) begin
            tov_d = tov_q + 4'h1;
            case (ts_q)
                ST_IDLE: begin
                    tout_d = 1'b1;
                    if (thr_full_q) begin
                        tsh_d = thr_q;
                        tpar_d = 1'b0;
                        tov_d = 4'h0;
                        tout_d = 1'b0; // R10
                        ts_d = ST_START;
                    end
                end
                ST_START: begin
                    if (tov_q == OVS) begin
                        tbit_d = 3'h0;
                        tout_d = tsh_q[0]; // R10
                        tpar_d = tsh_q[0];
                        ts_d = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (tov_q == OVS) begin
                        tbit_d = tbit_q + 3'h1;
                        if (tbit_q == nbits) begin
                            if (lcr_q[LC_PEN]) begin
                                tout_d = par_of(lcr_q, tpar_q); // R6
                                ts_d = ST_PAR;
                            end else begin
                                tout_d = 1'b1;
                                tstop_d = 2'h0;
                                ts_d = ST_STOP;
                            end
                        end else begin
                            tout_d = tsh_q[tbit_q + 3'h1];
                            tpar_d = tpar_q ^ tsh_q[tbit_q + 3'h1];
                        end
                    end
                end
                ST_PAR: begin
                    if (tov_q == OVS) begin
                        tout_d = 1'b1;
                        tstop_d = 2'h0;
                        ts_d = ST_STOP;
                    end
                end
                ST_STOP: begin
                    // Half-bit steps: 2, 3 or 4 of them
                    if (tov_q == OVS || tov_q == OVS_HALF) begin
                        tstop_d = tstop_q + 2'h1;
                        if (!lcr_q[LC_STB] && tstop_q == 2'h1) begin
                            ts_d = ST_IDLE; // R7
                        end else if (lcr_q[LC_STB] && lcr_q[1:0] == 2'h0 && tstop_q == 2'h2) begin
                            ts_d = ST_IDLE; // R7
                        end else if (tstop_q == 2'h3) begin
                            ts_d = ST_IDLE; // R7
                        end
                    end
                end
                default: ts_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ts_q <= ST_IDLE;
            tov_q <= 4'h0;
            tbit_q <= 3'h0;
            tsh_q <= 8'h00;
            tpar_q <= 1'b0;
            tstop_q <= 2'h0;
            tout_q <= 1'b1;
        end else begin
            ts_q <= ts_d;
            tov_q <= tov_d;
            tbit_q <= tbit_d;
            tsh_q <= tsh_d;
            tpar_q <= tpar_d;
            tstop_q <= tstop_d;
            tout_q <= tout_d;
        end
    end

    // Receive framing, sampling mid-bit; first stop bit checked
    always_comb begin
        rs_d = rs_q;
        rov_d = rov_q;
        rbit_d = rbit_q;
        rsh_d = rsh_q;
        rpar_d = rpar_q;
        rx_done = 1'b0;
        rx_perr = 1'b0;
        rx_ferr = 1'b0;
        if (tick) begin
            rov_d = rov_q + 4'h1;
            case (rs_q)
                ST_IDLE: begin
                    rov_d = 4'h0;
                    if (!serial_in_i) begin
                        rs_d = ST_START;
                    end
                end
                ST_START: begin
                    if (rov_q == OVS_HALF) begin
                        rov_d = 4'h0;
                        rbit_d = 3'h0;
                        rsh_d = 8'h00;
                        rpar_d = 1'b0;
                        rs_d = serial_in_i ? ST_IDLE : ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (rov_q == OVS) begin
                        rsh_d[rbit_q] = serial_in_i; // R10
                        rpar_d = rpar_q ^ serial_in_i;
                        rbit_d = rbit_q + 3'h1;
                        if (rbit_q == nbits) begin
                            rs_d = lcr_q[LC_PEN] ? ST_PAR : ST_STOP; // R6
                        end
                    end
                end
                ST_PAR: begin
                    if (rov_q == OVS) begin
                        rpar_d = (serial_in_i != par_of(lcr_q, rpar_q)); // R4 R5
                        rs_d = ST_STOP;
                    end
                end
                ST_STOP: begin
                    if (rov_q == OVS) begin
                        rx_done = 1'b1;
                        rx_ferr = ~serial_in_i; // R7
                        rx_perr = lcr_q[LC_PEN] & rpar_q;
                        rs_d = ST_IDLE;
                    end
                end
                default: rs_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rs_q <= ST_IDLE;
            rov_q <= 4'h0;
            rbit_q <= 3'h0;
            rsh_q <= 8'h00;
            rpar_q <= 1'b0;
        end else begin
            rs_q <= rs_d;
            rov_q <= rov_d;
            rbit_q <= rbit_d;
            rsh_q <= rsh_d;
            rpar_q <= rpar_d;
        end
    end

    // Checks
    silence_low_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        lcr_q[LC_SIL] |-> !infrared_tx_out_o) else $error("infrared not silent"); // R3
    silence_pass_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !lcr_q[LC_SIL] |-> infrared_tx_out_o == serial_out_o) else $error("infrared not following"); // R3
    div_low_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (acc && avs_write_i && avs_address_i == OFS_DATA && lcr_q[LC_DLAB])
        |=> div_q[7:0] == $past(avs_writedata_i) && !thr_full_q == !$past(thr_full_q & ~tx_take))
        else $error("divisor low not written"); // R1
    div_high_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (acc && avs_write_i && avs_address_i == OFS_IEN && lcr_q[LC_DLAB])
        |=> div_q[15:8] == $past(avs_writedata_i) && $stable(ien_q)) else $error("divisor high not written"); // R1
    tx_load_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (acc && avs_write_i && avs_address_i == OFS_DATA && !lcr_q[LC_DLAB])
        |=> thr_full_q && thr_q == $past(avs_writedata_i) && $stable(div_q)) else $error("tx buffer not loaded"); // R2
    rx_read_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (acc && avs_read_i && avs_address_i == OFS_DATA && !lcr_q[LC_DLAB])
        |=> avs_readdata_o == $past(rxbuf_q)) else $error("rx buffer not read"); // R2
    start_low_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ts_q == ST_START |-> !serial_out_o) else $error("start bit not low"); // R10
    stop_high_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ts_q == ST_STOP |-> serial_out_o) else $error("stop bit not high"); // R7
    fixed_par_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (ts_q == ST_PAR && lcr_q[LC_PEN] && lcr_q[LC_FIX]) |-> serial_out_o == ~lcr_q[LC_EVEN])
        else $error("fixed parity wrong"); // R4
    no_par_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !lcr_q[LC_PEN] && ts_q == ST_DATA |=> ts_q != ST_PAR) else $error("parity without enable"); // R6
    bit_count_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ts_q == ST_DATA |-> tbit_q <= nbits) else $error("too many data bits"); // R8
    tick_rate_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (tick && div_q == 16'h0002 && $stable(div_q)) |=> !tick ##1 tick) else $error("baud tick spacing"); // R9
endmodule : uart_line_format_control

// *** tb/uart_remote_model.sv ***
module uart_remote_model (
    // Clock
    input wire logic mclk_i,
    // Serial line
    input wire logic line_i,
    output logic line_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bit time in clocks and bits captured before the stop bit
    int bit_clks = 32;
    int frame_bits = 9;
    int cyc = 0;
    logic [11:0] raw_q[$];
    int start_q[$];

    // Free cycle count used to time frame starts
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
    end

    // Capture each frame at bit centres, first stop bit included
    initial begin : capture
        logic [11:0] raw;
        int t;
        line_o = 1'b1;
        forever begin
            @(negedge line_i);
            t = cyc;
            raw = 12'hFFF;
            repeat (bit_clks / 2) @(posedge mclk_i);
            for (int i = 0; i <= frame_bits; i++) begin
                raw[i] = line_i;
                if (i < frame_bits) begin
                    repeat (bit_clks) @(posedge mclk_i);
                end
            end
            raw_q.push_back(raw);
            start_q.push_back(t);
        end
    end

    // Send start, data and parity bits, then hold the idle level for the stop time
    task automatic send_frame(input logic [11:0] bits, input int nb, input int stop_clks);
        for (int i = 0; i < nb; i++) begin
            line_o <= bits[i];
            repeat (bit_clks) @(posedge mclk_i);
        end
        line_o <= 1'b1;
        repeat (stop_clks) @(posedge mclk_i);
    endtask : send_frame
endmodule : uart_remote_model

// *** tb/uart_line_format_control_bench.sv ***
module uart_line_format_control_bench;
    import uart_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_i;
    logic rstn_i;
    logic [ADDR_W-1:0] avs_address_i;
    logic avs_read_i;
    logic avs_write_i;
    logic [DATA_W-1:0] avs_writedata_i;
    logic [DATA_W-1:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic serial_in_i;
    logic serial_out_o;
    logic infrared_tx_out_o;
    logic irq_o;
    int error_cnt = 0;
    int compares = 0;
    int cyc_cnt = 0;
    logic [7:0] cfgs [8] = '{8'h00, 8'h04, 8'h09, 8'h1B, 8'h2B, 8'h3A, 8'h0E, 8'h07};

    // Clock at 4 ns
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    uart_line_format_control uart_line_format_control_inst (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
        .infrared_tx_out_o(infrared_tx_out_o), .irq_o(irq_o));

    uart_remote_model uart_remote_model_inst (.mclk_i(mclk_i), .line_i(serial_out_o), .line_o(serial_in_i));

    task automatic conclude();
        if (error_cnt == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // Hang guard
    always @(posedge mclk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 80000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t %s: seen %h expected %h", $time, msg, seen, exp);
        end
    endtask : check

    // One Avalon access; request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic [2:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge mclk_i);
        avs_address_i <= a;
        avs_write_i <= w;
        avs_read_i <= ~w;
        avs_writedata_i <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            conclude();
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask : bus

    task automatic rd(input logic [2:0] a, output logic [7:0] q);
        bus(a, 1'b0, 8'h00, q);
    endtask : rd

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] x;
        bus(a, 1'b1, d, x);
    endtask : wr

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string msg);
        logic [7:0] q;
        rd(a, q);
        check(16'(q), 16'(exp), msg);
    endtask : rd_chk

    // Read line status until a bit is set, bounded
    task automatic poll(input int b, output logic [7:0] q);
        int k;
        k = 0;
        do begin
            rd(OFS_LSR, q);
            k++;
        end while (q[b] !== 1'b1 && k < 800);
    endtask : poll

    task automatic wait_frames(input int cnt);
        int k;
        k = 0;
        while (uart_remote_model_inst.raw_q.size() < cnt && k < 3000) begin
            @(posedge mclk_i);
            k++;
        end
    endtask : wait_frames

    task automatic irq_chk(input logic exp, input string msg);
        @(negedge mclk_i);
        check(16'(irq_o), 16'(exp), msg);
    endtask : irq_chk

    // Expected line bits: start, data least significant first, optional parity
    function automatic logic [11:0] frame_of(input logic [7:0] lc, input logic [7:0] c);
        logic [11:0] r;
        logic [7:0] d;
        int n;
        n = 5 + int'(lc[1:0]);
        d = c & (8'hFF >> (8 - n));
        r = 12'hFFE;
        for (int j = 0; j < n; j++) begin
            r[1 + j] = d[j];
        end
        if (lc[LC_PEN]) begin
            r[1 + n] = lc[LC_FIX] ? ~lc[LC_EVEN] : (lc[LC_EVEN] ? ^d : ~^d);
        end
        return r;
    endfunction : frame_of

    initial begin
        logic [7:0] q;
        logic [7:0] c;
        logic [7:0] lc;
        logic [11:0] r;
        int n;
        int fb;
        int sc;
        int t0;
        int t1;
        int bad;
        rstn_i = 1'b0;
        avs_address_i = 3'h0;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 8'h00;
        repeat (4) @(posedge mclk_i);
        rstn_i <= 1'b1;
        // Register map and divisor access switching
        rd_chk(OFS_LCR, 8'h00, "format reset");
        wr(OFS_IEN, 8'h01);
        wr(OFS_SCR, 8'h5A);
        wr(OFS_LCR, 8'h83);
        rd_chk(OFS_DATA, 8'h01, "divisor low reset");
        rd_chk(OFS_IEN, 8'h00, "divisor high reset");
        wr(OFS_DATA, 8'h02);
        wr(OFS_IEN, 8'h00);
        rd_chk(OFS_DATA, 8'h02, "divisor low");
        wr(OFS_LCR, 8'h03);
        rd_chk(OFS_IEN, 8'h01, "enable kept");
        wr(OFS_IID, 8'hFF);
        wr(OFS_MSR, 8'hFF);
        rd_chk(OFS_SCR, 8'h5A, "scratch");
        rd_chk(OFS_MSR, 8'h00, "modem status");
        rd_chk(OFS_LCR, 8'h03, "format");
        wr(OFS_MCR, 8'h08);
        // Every length, stop and parity mode, sent back to back and received
        foreach (cfgs[i]) begin
            lc = cfgs[i];
            c = 8'hB3 ^ 8'(i * 37);
            n = 5 + int'(lc[1:0]);
            fb = 1 + n + int'(lc[LC_PEN]);
            sc = !lc[LC_STB] ? 32 : (n == 5 ? 48 : 64);
            r = frame_of(lc, c);
            wr(OFS_LCR, lc);
            uart_remote_model_inst.frame_bits = fb;
            wr(OFS_DATA, c);
            poll(5, q);
            wr(OFS_DATA, c);
            wait_frames(2);
            t0 = uart_remote_model_inst.start_q.pop_front();
            t1 = uart_remote_model_inst.start_q.pop_front();
            check(16'(uart_remote_model_inst.raw_q.pop_front()), 16'(r), "tx frame");
            check(16'(uart_remote_model_inst.raw_q.pop_front()), 16'(r), "tx frame");
            check(16'((t1 - t0 - fb * 32 - sc) inside {[-2:2]}), 16'h0001, "frame spacing");
            uart_remote_model_inst.send_frame(r, fb, sc);
            poll(0, q);
            check(16'(q & 8'h0D), 16'h0001, "rx status");
            irq_chk(1'b1, "irq raised");
            rd(OFS_DATA, q);
            check(16'(q & (8'hFF >> (8 - n))), 16'(c & (8'hFF >> (8 - n))), "rx data");
            irq_chk(1'b0, "irq cleared");
        end
        // Wrong parity, interrupt masked then enabled
        wr(OFS_IEN, 8'h00);
        wr(OFS_LCR, 8'h1B);
        r = frame_of(8'h1B, 8'h5C);
        r[9] = ~r[9];
        uart_remote_model_inst.send_frame(r, 10, 32);
        poll(0, q);
        check(16'(q & 8'h0D), 16'h0005, "parity error");
        irq_chk(1'b0, "irq masked");
        wr(OFS_IEN, 8'h01);
        irq_chk(1'b1, "irq unmasked");
        rd_chk(OFS_IID, 8'h04, "interrupt source");
        rd(OFS_DATA, q);
        irq_chk(1'b0, "irq cleared");
        // Missing stop bit
        wr(OFS_LCR, 8'h03);
        r = frame_of(8'h03, 8'h21);
        r[9] = 1'b0;
        uart_remote_model_inst.send_frame(r, 10, 32);
        poll(0, q);
        check(16'(q & 8'h08), 16'h0008, "stop error");
        rd(OFS_DATA, q);
        // Forced silence on the infrared output only
        uart_remote_model_inst.frame_bits = 9;
        for (int s = 1; s >= 0; s--) begin
            wr(OFS_LCR, s ? 8'h43 : 8'h03);
            wr(OFS_DATA, 8'h96);
            bad = 0;
            repeat (400) begin
                @(negedge mclk_i);
                if (infrared_tx_out_o !== (s ? 1'b0 : serial_out_o)) begin
                    bad++;
                end
            end
            check(16'(bad), 16'h0000, "infrared level");
            wait_frames(1);
            t0 = uart_remote_model_inst.start_q.pop_front();
            check(16'(uart_remote_model_inst.raw_q.pop_front()), 16'(frame_of(8'h03, 8'h96)), "tx kept");
        end
        conclude();
    end
endmodule : uart_line_format_control_bench
